// File: hdl/cpsc_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: halt instruction enters Halt, issues Halt cycle
// RQ2: halt low power only after bus disconnect
// RQ3: stop-clock in Halt: reconnect, then Stop Grant cycle
// RQ4: stop-clock release returns to Halt, new cycle
// RQ5: wake events or reset leave Halt, reconnecting
// RQ6: stop-clock enters Stop Grant, issues cycle
// RQ7: Stop Grant low power after bus disconnect
// RQ8: controller connects bus before probing
// RQ9: controller disconnects bus after probes
// RQ10: Stop Grant latches wake events for later
// RQ11: Stop Grant exits on release or reset
// RQ12: resume services latched events at boundary
// RQ13: reset in Stop Grant starts reset process
// RQ14: southbridge throttles stop-clock while overtemperature
// RQ15: no probes in C3 Stop Grant
// RQ16: southbridge releases stop-clock on resume event
// RQ17: bus connect in Halt/Stop Grant enters Probe
// RQ18: Probe answers probes as in Working
// RQ19: after probe return to prior state
// RQ20: low power again only after disconnect
// RQ21: system bus clock keeps running
// RQ22: bus connected in Probe, transitions, Working
// RQ23: reset outranks every other exit
module cpsc_ctrl
  import cpsc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   stop_clock_request_n,
  input  wire logic                   system_management_irq_n,
  input  wire logic                   maskable_irq_request,
  input  wire logic                   nmi_request,
  input  wire logic                   warm_init_n,
  input  wire logic                   lapic_message,
  input  wire logic                   halt_instruction,
  input  wire logic                   bus_connected,
  input  wire logic                   cycle_done,
  input  wire logic                   events_taken,
  output logic                        connect_request,
  output logic                        cycle_valid,
  output logic [1:0]                  cycle_code,
  output logic                        low_power,
  output logic                        probe_active,
  output logic                        executing,
  output logic                        reset_process,
  output logic [CPSC_EVT_W-1:0]       pending_events,
  output cpsc_pkg::cpsc_state_e       power_state
);
  import cpsc_pkg::*;

  cpsc_state_e              state_r;
  cpsc_state_e              state_nxt;
  cpsc_state_e              probe_ret_r;
  cpsc_state_e              probe_ret_nxt;
  logic                     sg_from_halt_r;
  logic                     sg_from_halt_nxt;
  logic                     stop_clock_request_n_n_s;
  logic                     smi_n_s;
  logic                     maskable_irq_request_s;
  logic                     nmi_s;
  logic                     init_n_s;
  logic                     reset_s;
  logic [CPSC_EVT_W-1:0]    evt_now;
  logic [CPSC_EVT_W-1:0]    pend_r;
  logic                     wake;
  logic                     in_stop_grant;
  logic                     cycle_r;
  logic [1:0]               code_r;

  // reset pin also synchronised: async reset clears state, the sync copy
  // lets a reset pulse seen mid-state drive the reset process output
  cpsc_sync #(.RESET_VAL(1'b1)) u_sync_stp (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (stop_clock_request_n),
    .level_out (stop_clock_request_n_n_s)
  );
  cpsc_sync #(.RESET_VAL(1'b1)) u_sync_smi (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (system_management_irq_n),
    .level_out (smi_n_s)
  );
  cpsc_sync #(.RESET_VAL(1'b0)) u_sync_maskable_irq_request (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (maskable_irq_request),
    .level_out (maskable_irq_request_s)
  );
  cpsc_sync #(.RESET_VAL(1'b0)) u_sync_nmi (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (nmi_request),
    .level_out (nmi_s)
  );
  cpsc_sync #(.RESET_VAL(1'b1)) u_sync_init (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (warm_init_n),
    .level_out (init_n_s)
  );
  cpsc_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (reset),
    .level_out (reset_s)
  );

  always_comb
  begin
    evt_now                = '0;
    evt_now[CPSC_EVT_INIT]  = ~init_n_s;
    evt_now[CPSC_EVT_MASKABLE_IRQ_REQUEST]  = maskable_irq_request_s;
    evt_now[CPSC_EVT_NMI]   = nmi_s;
    evt_now[CPSC_EVT_SMI]   = ~smi_n_s;
    // message arrives from same-clock logic, no synchroniser
    evt_now[CPSC_EVT_LAPIC] = lapic_message;
  end

  assign in_stop_grant = (state_r == CPSC_SG_CONNECT) || (state_r == CPSC_SG_CYCLE) ||
                         (state_r == CPSC_STOP_GRANT) || (state_r == CPSC_SG_LOW) ||
                         ((state_r == CPSC_PROBE) && (probe_ret_r == CPSC_STOP_GRANT));
  assign wake = |evt_now;

  // latched events: the consume pulse clears them in Working, where new events are not latched
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pend_r <= '0;
    else if (reset_s)
      pend_r <= '0; // RQ13
    else if (in_stop_grant)
      pend_r <= pend_r | evt_now; // RQ10
    else if (events_taken && (state_r == CPSC_WORKING))
      pend_r <= '0; // RQ12
  end

  // exit-connect from Stop Grant entered out of Halt must go back to Halt
  function automatic logic in_stop_grant_prev(input cpsc_state_e ret);
    in_stop_grant_prev = (ret == CPSC_STOP_GRANT);
  endfunction

  function automatic logic is_low_state(input cpsc_state_e s);
    is_low_state = (s == CPSC_HALT_LOW) || (s == CPSC_SG_LOW);
  endfunction

  // every state in which the device itself holds the bus connected
  function automatic logic needs_bus(input cpsc_state_e s);
    needs_bus = (s == CPSC_WORKING) || (s == CPSC_HALT_CYCLE) || (s == CPSC_SG_CONNECT) ||
                (s == CPSC_SG_CYCLE) || (s == CPSC_EXIT_CONNECT);
  endfunction

  always_comb
  begin
    state_nxt        = state_r;
    probe_ret_nxt    = probe_ret_r;
    sg_from_halt_nxt = sg_from_halt_r;
    if (reset_s)
    begin
      state_nxt        = CPSC_WORKING; // RQ23
      sg_from_halt_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        CPSC_WORKING:
        begin
          if (!stop_clock_request_n_n_s)
          begin
            state_nxt        = CPSC_SG_CYCLE; // RQ6
            sg_from_halt_nxt = 1'b0;
          end
          else if (halt_instruction)
            state_nxt = CPSC_HALT_CYCLE; // RQ1
        end
        CPSC_HALT_CYCLE:
          if (cycle_done)
            state_nxt = CPSC_HALT;
        CPSC_HALT, CPSC_HALT_LOW:
        begin
          if (!stop_clock_request_n_n_s)
          begin
            state_nxt        = bus_connected ? CPSC_SG_CYCLE : CPSC_SG_CONNECT; // RQ3
            sg_from_halt_nxt = 1'b1;
          end
          else if (wake)
            state_nxt = bus_connected ? CPSC_WORKING : CPSC_EXIT_CONNECT; // RQ5
          else if (state_r == CPSC_HALT && !bus_connected)
            state_nxt = CPSC_HALT_LOW; // RQ2 RQ20
          else if (state_r == CPSC_HALT_LOW && bus_connected)
          begin
            state_nxt     = CPSC_PROBE; // RQ17
            probe_ret_nxt = CPSC_HALT;
          end
        end
        CPSC_SG_CONNECT:
          if (bus_connected)
            state_nxt = CPSC_SG_CYCLE; // RQ3
        CPSC_SG_CYCLE:
          if (cycle_done)
            state_nxt = CPSC_STOP_GRANT;
        CPSC_STOP_GRANT, CPSC_SG_LOW:
        begin
          if (stop_clock_request_n_n_s)
          begin
            if (!bus_connected)
              state_nxt = CPSC_EXIT_CONNECT; // RQ11
            else if (sg_from_halt_r)
              state_nxt = CPSC_HALT_CYCLE; // RQ4
            else
              state_nxt = CPSC_WORKING; // RQ12
          end
          else if (state_r == CPSC_STOP_GRANT && !bus_connected)
            state_nxt = CPSC_SG_LOW; // RQ7 RQ20
          else if (state_r == CPSC_SG_LOW && bus_connected)
          begin
            state_nxt     = CPSC_PROBE; // RQ17
            probe_ret_nxt = CPSC_STOP_GRANT;
          end
        end
        CPSC_PROBE:
          // probes answered by the normal snoop path; leave on disconnect
          if (!bus_connected)
            state_nxt = (probe_ret_r == CPSC_HALT) ? CPSC_HALT_LOW : CPSC_SG_LOW; // RQ19 RQ20
          else if (probe_ret_r == CPSC_STOP_GRANT && stop_clock_request_n_n_s)
            state_nxt = sg_from_halt_r ? CPSC_HALT_CYCLE : CPSC_WORKING; // RQ11
          else if (probe_ret_r == CPSC_HALT && (wake || !stop_clock_request_n_n_s))
          begin
            state_nxt        = stop_clock_request_n_n_s ? CPSC_WORKING : CPSC_SG_CYCLE; // RQ5
            sg_from_halt_nxt = ~stop_clock_request_n_n_s;
          end
        CPSC_EXIT_CONNECT:
          if (bus_connected)
            state_nxt = (sg_from_halt_r && in_stop_grant_prev(probe_ret_r)) ? CPSC_HALT_CYCLE
                                                                            : CPSC_WORKING;
        // codes past the last state recover to Working
        default:
          state_nxt = CPSC_WORKING;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r        <= CPSC_WORKING;
      sg_from_halt_r <= 1'b0;
    end
    else
    begin
      state_r        <= state_nxt;
      sg_from_halt_r <= sg_from_halt_nxt;
    end
  end

  // remember Stop Grant as origin on any entry so an exit-connect returns right
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      probe_ret_r <= CPSC_HALT;
    else if (state_nxt == CPSC_STOP_GRANT || state_nxt == CPSC_SG_CYCLE)
      probe_ret_r <= CPSC_STOP_GRANT;
    else if (state_nxt == CPSC_HALT || state_nxt == CPSC_HALT_CYCLE)
      probe_ret_r <= CPSC_HALT;
    else
      probe_ret_r <= probe_ret_nxt;
  end

  // special cycle request held until the bus side acknowledges
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cycle_r <= 1'b0;
    else
      cycle_r <= (state_nxt == CPSC_HALT_CYCLE) || (state_nxt == CPSC_SG_CYCLE); // RQ1 RQ6
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      code_r <= 2'h0;
    else if (state_nxt == CPSC_SG_CYCLE)
      code_r <= CPSC_CYC_STOPGRANT; // RQ3 RQ6
    else if (state_nxt == CPSC_HALT_CYCLE)
      code_r <= CPSC_CYC_HALT; // RQ1 RQ4
    else
      code_r <= 2'h0;
  end

  // clock grid ramps down only once the controller has let go of the bus
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      low_power <= 1'b0;
    else
      low_power <= is_low_state(state_nxt); // RQ2 RQ7
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      probe_active <= 1'b0;
    else
      probe_active <= (state_nxt == CPSC_PROBE); // RQ18
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      executing <= 1'b1;
    else
      executing <= (state_nxt == CPSC_WORKING);
  end

  // sync copy outlives the async reset by a few edges
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reset_process <= 1'b0;
    else
      reset_process <= reset_s; // RQ13
  end

  // ask for the bus in Working, the cycle and connect states; Probe is held by the controller
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      connect_request <= 1'b1;
    else
      connect_request <= needs_bus(state_nxt); // RQ22
  end

  assign cycle_valid    = cycle_r;
  assign cycle_code     = code_r;
  assign pending_events = pend_r;
  assign power_state    = state_r;
endmodule

// File: hdl/cpsc_pkg.sv
package cpsc_pkg;

  // main controller states
  typedef enum logic [3:0] {
    CPSC_WORKING,
    CPSC_HALT_CYCLE,
    CPSC_HALT,
    CPSC_HALT_LOW,
    CPSC_SG_CONNECT,
    CPSC_SG_CYCLE,
    CPSC_STOP_GRANT,
    CPSC_SG_LOW,
    CPSC_PROBE,
    CPSC_EXIT_CONNECT
  } cpsc_state_e;

  // special cycle codes on the cycle port
  localparam logic [1:0] CPSC_CYC_HALT      = 2'h1;
  localparam logic [1:0] CPSC_CYC_STOPGRANT = 2'h2;

  // latched wake event bit positions
  localparam int CPSC_EVT_INIT  = 0;
  localparam int CPSC_EVT_MASKABLE_IRQ_REQUEST  = 1;
  localparam int CPSC_EVT_NMI   = 2;
  localparam int CPSC_EVT_SMI   = 3;
  localparam int CPSC_EVT_LAPIC = 4;
  localparam int CPSC_EVT_W     = 5;

  // synchroniser depth for pin inputs
  localparam int CPSC_SYNC_STAGES = 3;

endpackage

// File: hdl/cpsc_sync.sv
`timescale 1ns/1ns
// three-flop pin synchroniser; output moves once stages two and three agree
module cpsc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      level_out <= RESET_VAL;
    else if (s2_r == s3_r)
      level_out <= s3_r;
  end
endmodule

// File: testbench/cpsc_ctrl_checker.sv
`timescale 1ns/1ns
module cpsc_ctrl_checker
  import cpsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       halt_instruction,
  input wire logic       bus_connected,
  input wire logic       cycle_done,
  input wire logic       connect_request,
  input wire logic       cycle_valid,
  input wire logic [1:0] cycle_code,
  input wire logic       low_power,
  input wire logic       probe_active,
  input wire logic       executing,
  input wire logic       reset_process
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_probe_req;
    low_power && bus_connected && !connect_request;
  endsequence
  halt_cycle_a: assert property (
    executing && halt_instruction && !reset_process |=> cycle_valid && cycle_code == CPSC_CYC_HALT)
    else $error("halt cycle not issued");
  low_disc_a: assert property (
    $rose(low_power) |-> !$past(bus_connected))
    else $error("low power with bus connected");
  cycle_hold_a: assert property (
    cycle_valid && !cycle_done |=> cycle_valid && $stable(cycle_code))
    else $error("special cycle dropped early");
  cycle_on_bus_a: assert property (
    $rose(cycle_valid) |-> $past(bus_connected))
    else $error("special cycle while disconnected");
  probe_entry_a: assert property (
    s_probe_req |-> ##[1:2] probe_active)
    else $error("probe not entered");
  probe_return_a: assert property (
    $fell(probe_active) |-> low_power)
    else $error("probe did not return to low power");
  work_bus_a: assert property (
    executing |-> bus_connected)
    else $error("working without bus");
  reset_wins_a: assert property (
    reset_process |-> executing && !low_power && !cycle_valid)
    else $error("state moved during reset");
endmodule

bind cpsc_ctrl cpsc_ctrl_checker i_cpsc_ctrl_checker (
  .clk              (clk),
  .reset            (reset),
  .halt_instruction (halt_instruction),
  .bus_connected    (bus_connected),
  .cycle_done       (cycle_done),
  .connect_request  (connect_request),
  .cycle_valid      (cycle_valid),
  .cycle_code       (cycle_code),
  .low_power        (low_power),
  .probe_active     (probe_active),
  .executing        (executing),
  .reset_process    (reset_process)
);

// File: testbench/cpsc_nb_model.sv
`timescale 1ns/1ns
// system controller: answers special cycles, connects and disconnects the bus
module cpsc_nb_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       connect_request,
  input  wire logic       cycle_valid,
  input  wire logic       probe_go,
  input  wire logic [2:0] done_wait,
  output logic            bus_connected,
  output logic            cycle_done
);
  logic [2:0] wait_r;
  logic       req_d_r;
  logic       probe_d_r;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wait_r        <= 3'h0;
      cycle_done    <= 1'b0;
      req_d_r       <= 1'b1;
      probe_d_r     <= 1'b0;
      bus_connected <= 1'b1;
    end
    else
    begin
      cycle_done <= 1'b0;
      req_d_r    <= connect_request;
      probe_d_r  <= probe_go;
      // done_wait lets the bench play a slow controller
      if (!cycle_valid || cycle_done)
        wait_r <= 3'h0;
      else if (wait_r == done_wait)
        cycle_done <= 1'b1;
      else
        wait_r <= wait_r + 3'h1;
      if (probe_go || (connect_request && !req_d_r))
        bus_connected <= 1'b1;
      else if (cycle_done || (probe_d_r && !probe_go))
        bus_connected <= 1'b0;
    end
  end
endmodule

// File: testbench/tb_cpu_power_state_control.sv
`timescale 1ns/1ns
module tb_cpu_power_state_control;
  import cpsc_pkg::*;
  logic              clk;
  logic              reset;
  logic              stop_n;
  logic              irq;
  logic              nmi;
  logic              smi_n;
  logic              init_n;
  logic              lapic_msg;
  logic              halt_instruction;
  logic              events_taken;
  logic              probe_go;
  logic [2:0]        done_wait;
  logic              bus_connected;
  logic              cycle_done;
  logic              connect_request;
  logic              cycle_valid;
  logic [1:0]        cycle_code;
  logic              low_power;
  logic              probe_active;
  logic              executing;
  logic              reset_process;
  logic [4:0]        pending_events;
  cpsc_state_e       power_state;
  int                bad_count;
  int                check_count;

  cpsc_ctrl i_cpsc_ctrl (.clk(clk), .reset(reset), .stop_clock_request_n(stop_n),
    .system_management_irq_n(smi_n), .maskable_irq_request(irq), .nmi_request(nmi),
    .warm_init_n(init_n), .lapic_message(lapic_msg), .halt_instruction(halt_instruction),
    .bus_connected(bus_connected), .cycle_done(cycle_done), .events_taken(events_taken),
    .connect_request(connect_request), .cycle_valid(cycle_valid), .cycle_code(cycle_code),
    .low_power(low_power), .probe_active(probe_active), .executing(executing),
    .reset_process(reset_process), .pending_events(pending_events), .power_state(power_state));
  cpsc_nb_model i_cpsc_nb_model (.clk(clk), .reset(reset), .connect_request(connect_request),
    .cycle_valid(cycle_valid), .probe_go(probe_go), .done_wait(done_wait),
    .bus_connected(bus_connected), .cycle_done(cycle_done));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_st(input cpsc_state_e s);
    for (int i = 0; i < 200 && power_state !== s; i++)
      @(negedge clk);
    chk(8'(power_state), 8'(s));
  endtask

  task automatic t_halt();
    halt_instruction = 1'b1;
    @(negedge clk);
    halt_instruction = 1'b0;
    chk(8'(cycle_code), 8'(CPSC_CYC_HALT));
    wait_st(CPSC_HALT_LOW);
    chk(8'(bus_connected), 8'h00);
    $display("halt test done");
  endtask

  // probes only outside C3, so the bench never probes in the reset test
  task automatic t_probe(input cpsc_state_e home);
    probe_go = 1'b1;
    wait_st(CPSC_PROBE);
    chk(8'(probe_active), 8'h01);
    probe_go = 1'b0;
    wait_st(home);
    chk(8'(low_power), 8'h01);
    $display("probe test done");
  endtask

  task automatic t_sg_halt();
    done_wait = 3'h3;
    stop_n = 1'b0;
    wait_st(CPSC_SG_CYCLE);
    chk(8'(bus_connected), 8'h01);
    wait_st(CPSC_SG_LOW);
    t_probe(CPSC_SG_LOW);
    irq = 1'b1;
    smi_n = 1'b0;
    lapic_msg = 1'b1;
    @(negedge clk);
    lapic_msg = 1'b0;
    repeat (5) @(negedge clk);
    irq = 1'b0;
    smi_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'(pending_events[CPSC_EVT_MASKABLE_IRQ_REQUEST]), 8'h01);
    chk(8'(pending_events), 8'h1A);
    stop_n = 1'b1;
    wait_st(CPSC_HALT_CYCLE);
    chk(8'(cycle_code), 8'(CPSC_CYC_HALT));
    done_wait = 3'h0;
    nmi = 1'b1;
    wait_st(CPSC_WORKING);
    chk(8'(bus_connected), 8'h01);
    nmi = 1'b0;
    repeat (5) @(negedge clk);
    chk(8'(pending_events[CPSC_EVT_MASKABLE_IRQ_REQUEST]), 8'h01);
    events_taken = 1'b1;
    @(negedge clk);
    events_taken = 1'b0;
    @(negedge clk);
    chk(8'(pending_events), 8'h00);
    $display("stop grant from halt test done");
  endtask

  // halt pulse outside Working is refused; warm init wakes Halt through a reconnect
  task automatic t_init_wake();
    t_halt();
    halt_instruction = 1'b1;
    @(negedge clk);
    halt_instruction = 1'b0;
    chk(8'(cycle_valid), 8'h00);
    init_n = 1'b0;
    wait_st(CPSC_WORKING);
    chk(8'(connect_request), 8'h01);
    init_n = 1'b1;
    repeat (6) @(negedge clk);
    $display("init wake test done");
  endtask

  task automatic t_sg_work();
    for (int k = 0; k < 2; k++)
    begin
      stop_n = 1'b0;
      wait_st(CPSC_SG_CYCLE);
      chk(8'(cycle_code), 8'(CPSC_CYC_STOPGRANT));
      wait_st(CPSC_SG_LOW);
      reset = k[0];
      stop_n = 1'b1;
      @(negedge clk);
      wait_st(CPSC_WORKING);
      chk(8'(executing), 8'h01);
      reset = 1'b0;
      @(negedge clk);
      chk(8'(reset_process), 8'(k));
      repeat (7) @(negedge clk);
    end
    $display("stop grant from working test done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    {stop_n, irq, nmi, halt_instruction, events_taken, probe_go} = 6'h20;
    {smi_n, init_n, lapic_msg} = 3'h6;
    done_wait = 3'h0;
    bad_count = 0;
    check_count = 0;
    reset = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    chk(8'(executing), 8'h01);
    t_halt();
    t_probe(CPSC_HALT_LOW);
    t_sg_halt();
    t_init_wake();
    t_sg_work();
    give_verdict();
  end
endmodule
